// file: rsc_far_side.sv
`timescale 1ns/1ps

// -----------------------------------------------------------------
// Reset network, supply monitor and watchdog seen from the block
// -----------------------------------------------------------------
module rsc_far_side #(
  parameter int SUB_DIV = 8
)(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Requests from the bench
  input wire logic pinLowReq,
  input wire logic supplyLowReq,
  input wire logic dogReq,
  // Towards the block
  output logic extRstPinN,
  output logic lowSupplyRaw,
  output logic subClkTick,
  output logic dogTimeout
);
  logic [7:0] divCnt;

  // The pin has a pull-up, so it rests high unless pulled down
  assign extRstPinN = ~pinLowReq;
  assign lowSupplyRaw = supplyLowReq;
  assign dogTimeout = dogReq;

  // Slow oscillator runs freely, also while the core is held in reset, but is held at zero while reset_n is low
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      divCnt <= 8'h00;
      subClkTick <= 1'b0;
    end
    else
    begin
      divCnt <= (divCnt == 8'(SUB_DIV - 1)) ? 8'h00 : divCnt + 8'h01;
      subClkTick <= (divCnt == 8'h00);
    end
  end
endmodule

// file: rsc_pkg.sv
package rsc_pkg;

  // -----------------------------------------------------------------
  // Register map (APB byte addresses)
  // -----------------------------------------------------------------
  localparam logic [11:0] ADDR_THRESH = 12'h000;
  localparam logic [11:0] ADDR_CAUSE = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;

  // -----------------------------------------------------------------
  // Field layout and reset values
  // -----------------------------------------------------------------
  localparam logic [7:0] THRESH_POR = 8'h55;
  localparam logic [7:0] CODE_2V10 = 8'h55;
  localparam logic [7:0] CODE_2V55 = 8'h33;
  localparam logic [7:0] CODE_3V15 = 8'h99;
  localparam logic [7:0] CODE_3V80 = 8'hAA;
  localparam logic [4:0] DOG_ENABLE = 5'h0A;
  localparam logic [4:0] DOG_DISABLE = 5'h15;
  localparam int CAUSE_KEEP_BIT = 7;
  localparam int CAUSE_UV_BIT = 2;
  localparam int CAUSE_THR_BIT = 1;
  localparam int CAUSE_DOG_BIT = 0;
  localparam int STAT_TO_BIT = 0;
  localparam int STAT_PD_BIT = 1;
  localparam int STAT_HOLD_BIT = 2;
  localparam logic [7:0] PORT_POR = 8'hFF;

  // -----------------------------------------------------------------
  // Timing
  // -----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int POR_DELAY_US = 50000;
  localparam int RST_DELAY_US = 16700;
  localparam int POR_DELAY_CYC = POR_DELAY_US * CLK_MHZ;
  localparam int RST_DELAY_CYC = RST_DELAY_US * CLK_MHZ;
  localparam int SST_XTAL_CYC = 1024;
  localparam int SST_RC_CYC = 2;
  localparam int CODE_ERR_SUBS = 2;

  // -----------------------------------------------------------------
  // Types
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    RSC_HOLD = 2'b00,
    RSC_DELAY = 2'b01,
    RSC_SST = 2'b11,
    RSC_RUN = 2'b10
  } rsc_phase_e;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } rsc_apb_rsp_s;

endpackage

// file: rsc_reset_ctrl.sv
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/1ps

// Overview of operation
// - Selected external pin low resets device and restarts at address zero.
// - Pin acts as reset only when option selects it, else port pin.
// - Power-on loads port data and direction registers with all ones.
// - After power-on, hold execution for a 50 ms delay.
// - After pin, undervoltage or normal watchdog reset, wait 16.7 ms.
// - While pin held low, drive one pin low, others high impedance.
// - Undervoltage longer than minimum resets and sets flag; shorter ignored.
// - Four threshold codes 55h,33h,99h,AAh select the undervoltage levels.
// - Bad threshold code resets after 2-3 sub clocks, flags, restores 55h (here after 1-2).
// - Real undervoltage reset acts after 2-3 sub clocks, keeps threshold (here after 1-2).
// - Threshold select register powers on as 55h.
// - Undervoltage reset is disabled during power-down, active otherwise.
// - Cause bit 2 set by undervoltage reset, cleared only by software.
// - Cause bit 1 set by bad threshold code, cleared only by software.
// - Cause bits 6 to 3 always read zero.
// - Running watchdog timeout resets like the pin and sets timeout flag.
// - Sleep watchdog timeout clears only program counter and stack pointer.
// - Start-up timer counts 1024 cycles for crystal, 1-2 for RC.
// - Timeout/power-down flags: POR clears, pin/UV keep, dog sets per mode.
// - Bad dog enable code resets after 2-3 sub clocks and sets bit 0 (here after 1-2).
module rsc_reset_ctrl #(
  parameter int POR_CYC = rsc_pkg::POR_DELAY_CYC,
  parameter int RST_CYC = rsc_pkg::RST_DELAY_CYC,
  parameter int UV_MIN_CYC = 16
)(
  // Clock and power-on reset
  input wire logic mclk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Configuration and external events
  input wire logic extRstEnable,
  input wire logic extRstPinN,
  input wire logic lowSupplyRaw,
  input wire logic subClkTick,
  input wire logic crystalSource,
  input wire logic powerDown,
  input wire logic dogTimeout,
  input wire logic [4:0] dogEnableCode,
  // Reset outputs, shared port pin input and threshold level
  output logic coreRstN,
  output logic pcSpClear,
  output logic portsPreset,
  output logic [7:0] portPresetValue,
  output logic pinHoldActive,
  output logic lowDrivenPinOut,
  output logic lowDrivenPinOe,
  output logic sharedPortPinIn,
  output logic [1:0] thresholdLevel
);

  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------
  typedef struct packed {
    rsc_pkg::rsc_phase_e phase;
    logic [31:0] cnt;
    logic [1:0] pinSync;
    logic [1:0] uvSync;
    logic [1:0] dogSync;
    logic [7:0] uvCnt;
    logic [1:0] thrSubs;
    logic [1:0] dogSubs;
    logic [1:0] uvSubs;
    logic [7:0] thresh;
    logic uvFlag;
    logic thrFlag;
    logic dogFlag;
    logic keepClk;
    logic toFlag;
    logic pdFlag;
    logic porDone;
    logic wasPin;
    logic pcClr;
    logic [31:0] rdata;
  } rsc_state_s;

  rsc_state_s st_ff;
  rsc_state_s nxt_st;
  logic [1:0] rstSync_ff;
  logic pinLow;
  logic uvLow;
  logic dogEvt;
  logic dogPrev_ff;
  logic thrValid;
  logic dogValid;
  logic uvReset;
  logic hardReset;
  logic wrEn;
  logic rdEn;
  logic [7:0] wByte;

  // Glitch counter is 8 bits wide, delay counters need at least one cycle
  if (UV_MIN_CYC < 1 || UV_MIN_CYC > 255 || POR_CYC < 1 || RST_CYC < 1)
  begin
    $error("rsc_reset_ctrl: unsupported count parameter");
  end

  // -----------------------------------------------------------------
  // Decode
  // -----------------------------------------------------------------
  assign pinLow = extRstEnable && !st_ff.pinSync[1];
  assign uvLow = st_ff.uvSync[1] && !powerDown;
  assign dogEvt = st_ff.dogSync[1] && !dogPrev_ff;
  always_comb
  begin
    case (st_ff.thresh)
      rsc_pkg::CODE_2V10: thresholdLevel = 2'd0;
      rsc_pkg::CODE_2V55: thresholdLevel = 2'd1;
      rsc_pkg::CODE_3V15: thresholdLevel = 2'd2;
      rsc_pkg::CODE_3V80: thresholdLevel = 2'd3;
      default: thresholdLevel = 2'd0;
    endcase
  end
  assign thrValid = st_ff.thresh == rsc_pkg::CODE_2V10 ||
    st_ff.thresh == rsc_pkg::CODE_2V55 ||
    st_ff.thresh == rsc_pkg::CODE_3V15 ||
    st_ff.thresh == rsc_pkg::CODE_3V80;
  assign dogValid = dogEnableCode == rsc_pkg::DOG_ENABLE ||
    dogEnableCode == rsc_pkg::DOG_DISABLE;
  assign uvReset = st_ff.uvCnt >= 8'(UV_MIN_CYC);
  assign wrEn = psel && penable && pwrite && st_ff.phase == rsc_pkg::RSC_RUN;
  assign rdEn = psel && !penable && !pwrite;
  assign wByte = pstrb[0] ? pwdata[7:0] : 8'h00;

  // Code errors fire on the second sub-clock tick seen, i.e. 1-2 periods
  assign hardReset = pinLow ||
    (uvReset && st_ff.uvSubs == 2'(rsc_pkg::CODE_ERR_SUBS)) ||
    st_ff.thrSubs == 2'(rsc_pkg::CODE_ERR_SUBS) ||
    st_ff.dogSubs == 2'(rsc_pkg::CODE_ERR_SUBS) ||
    (dogEvt && !powerDown);

  // -----------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.pinSync = {st_ff.pinSync[0], extRstPinN};
    nxt_st.uvSync = {st_ff.uvSync[0], lowSupplyRaw};
    nxt_st.dogSync = {st_ff.dogSync[0], dogTimeout};
    nxt_st.pcClr = 1'b0;
    // Glitch filter: a short dip never reaches the threshold
    nxt_st.uvCnt = !uvLow ? 8'h00 :
      (uvReset ? st_ff.uvCnt : st_ff.uvCnt + 8'h01);
    if (!thrValid && subClkTick && st_ff.thrSubs != 2'd3)
      nxt_st.thrSubs = st_ff.thrSubs + 2'd1;
    if (thrValid)
      nxt_st.thrSubs = 2'd0;
    if (!dogValid && subClkTick && st_ff.dogSubs != 2'd3)
      nxt_st.dogSubs = st_ff.dogSubs + 2'd1;
    if (dogValid)
      nxt_st.dogSubs = 2'd0;
    if (uvReset && subClkTick && st_ff.uvSubs != 2'd3)
      nxt_st.uvSubs = st_ff.uvSubs + 2'd1;
    if (!uvReset)
      nxt_st.uvSubs = 2'd0;

    // Software side: flags cleared by writing zero, hardware set wins
    if (wrEn && paddr == rsc_pkg::ADDR_THRESH)
      nxt_st.thresh = wByte;
    if (wrEn && paddr == rsc_pkg::ADDR_CAUSE)
    begin
      nxt_st.keepClk = wByte[rsc_pkg::CAUSE_KEEP_BIT];
      nxt_st.uvFlag = st_ff.uvFlag & wByte[rsc_pkg::CAUSE_UV_BIT];
      nxt_st.thrFlag = st_ff.thrFlag & wByte[rsc_pkg::CAUSE_THR_BIT];
      nxt_st.dogFlag = st_ff.dogFlag & wByte[rsc_pkg::CAUSE_DOG_BIT];
    end
    if (wrEn && paddr == rsc_pkg::ADDR_STATUS)
    begin
      nxt_st.toFlag = wByte[rsc_pkg::STAT_TO_BIT];
      nxt_st.pdFlag = wByte[rsc_pkg::STAT_PD_BIT];
    end
    if (!thrValid)
      nxt_st.thrFlag = 1'b1;
    if (st_ff.thrSubs == 2'(rsc_pkg::CODE_ERR_SUBS))
      nxt_st.thresh = rsc_pkg::THRESH_POR;
    if (uvReset && st_ff.uvSubs == 2'(rsc_pkg::CODE_ERR_SUBS))
      nxt_st.uvFlag = 1'b1;
    if (st_ff.dogSubs == 2'(rsc_pkg::CODE_ERR_SUBS))
      nxt_st.dogFlag = 1'b1;
    if (dogEvt)
    begin
      nxt_st.toFlag = 1'b1;
      nxt_st.pdFlag = st_ff.pdFlag | powerDown;
      nxt_st.pcClr = powerDown;
    end

    // Sequencer: hold, delay, oscillator start-up, run
    case (st_ff.phase)
      rsc_pkg::RSC_HOLD:
      begin
        if (!hardReset)
        begin
          nxt_st.phase = rsc_pkg::RSC_DELAY;
          nxt_st.cnt = st_ff.porDone ? 32'(RST_CYC) : 32'(POR_CYC);
        end
      end
      rsc_pkg::RSC_DELAY:
      begin
        if (st_ff.cnt <= 32'd1)
        begin
          nxt_st.phase = rsc_pkg::RSC_SST;
          nxt_st.cnt = crystalSource ? 32'(rsc_pkg::SST_XTAL_CYC) :
            32'(rsc_pkg::SST_RC_CYC);
        end
        else
          nxt_st.cnt = st_ff.cnt - 32'd1;
      end
      rsc_pkg::RSC_SST:
      begin
        if (st_ff.cnt <= 32'd1)
        begin
          nxt_st.phase = rsc_pkg::RSC_RUN;
          nxt_st.porDone = 1'b1;
        end
        else
          nxt_st.cnt = st_ff.cnt - 32'd1;
      end
      rsc_pkg::RSC_RUN: nxt_st.cnt = 32'd0;
      default: nxt_st.phase = rsc_pkg::RSC_HOLD;
    endcase
    if (hardReset)
    begin
      nxt_st.phase = rsc_pkg::RSC_HOLD;
      nxt_st.wasPin = pinLow;
      nxt_st.thrSubs = 2'd0;
      nxt_st.dogSubs = 2'd0;
      nxt_st.uvSubs = 2'd0;
    end
    else
      nxt_st.wasPin = 1'b0;

    nxt_st.rdata = 32'h0;
    if (rdEn)
    begin
      case (paddr)
        rsc_pkg::ADDR_THRESH: nxt_st.rdata = {24'h0, st_ff.thresh};
        rsc_pkg::ADDR_CAUSE: nxt_st.rdata = {24'h0, st_ff.keepClk, 4'h0,
          st_ff.uvFlag, st_ff.thrFlag, st_ff.dogFlag};
        rsc_pkg::ADDR_STATUS: nxt_st.rdata = {29'h0,
          st_ff.phase != rsc_pkg::RSC_RUN, st_ff.pdFlag, st_ff.toFlag};
        default: nxt_st.rdata = 32'h0;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // Registers: power-on reset clears cause of timeout and power-down
  // -----------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_ff <= '0;
      st_ff.phase <= rsc_pkg::RSC_HOLD;
      st_ff.pinSync <= 2'b11;
      st_ff.thresh <= rsc_pkg::THRESH_POR;
      st_ff.toFlag <= 1'b0;
      st_ff.pdFlag <= 1'b0;
      dogPrev_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      dogPrev_ff <= st_ff.dogSync[1];
    end
  end

  // Core reset: asserted at once, released on a clock edge
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      rstSync_ff <= 2'b00;
    else if (hardReset)
      rstSync_ff <= 2'b00;
    else
      rstSync_ff <= {rstSync_ff[0], st_ff.phase == rsc_pkg::RSC_RUN};
  end

  // -----------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------
  assign coreRstN = rstSync_ff[1] && !hardReset;
  assign pcSpClear = st_ff.pcClr;
  assign portsPreset = !st_ff.porDone;
  assign portPresetValue = rsc_pkg::PORT_POR;
  assign pinHoldActive = st_ff.wasPin;
  assign lowDrivenPinOut = 1'b0;
  assign lowDrivenPinOe = st_ff.wasPin;
  assign sharedPortPinIn = extRstEnable ? 1'b1 : st_ff.pinSync[1];
  assign prdata = st_ff.rdata;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  a_pin_holds_core: assert property (@(posedge mclk) disable iff (!reset_n)
    pinLow |-> !coreRstN) else $error("pin low but core running");
  a_pin_option_off: assert property (@(posedge mclk) disable iff (!reset_n)
    !extRstEnable |-> !pinLow) else $error("pin reset while disabled");
  a_pin_drive_low: assert property (@(posedge mclk) disable iff (!reset_n)
    pinLow |=> lowDrivenPinOe && !lowDrivenPinOut)
    else $error("held pin not driven low");
  a_thr_restore: assert property (@(posedge mclk) disable iff (!reset_n)
    st_ff.thrSubs == 2'd2 |=> st_ff.thresh == 8'h55 && st_ff.thrFlag)
    else $error("bad code not restored");
  a_uv_flag_set: assert property (@(posedge mclk) disable iff (!reset_n)
    uvReset && st_ff.uvSubs == 2'd2 |=> st_ff.uvFlag && !coreRstN)
    else $error("undervoltage flag missing");
  a_uv_powerdown: assert property (@(posedge mclk) disable iff (!reset_n)
    powerDown && st_ff.uvSync[1] |=> st_ff.uvCnt == 8'h00)
    else $error("undervoltage active in power-down");
  a_cause_zero: assert property (@(posedge mclk) disable iff (!reset_n)
    $past(rdEn) |-> prdata[6:3] == 4'h0 || $past(paddr) != 12'h004)
    else $error("unimplemented bits nonzero");
  a_dog_sleep: assert property (@(posedge mclk) disable iff (!reset_n)
    dogEvt && powerDown |=> pcSpClear && st_ff.toFlag && st_ff.pdFlag)
    else $error("sleep timeout wrong");
  a_dog_run: assert property (@(posedge mclk) disable iff (!reset_n)
    dogEvt && !powerDown |=> st_ff.toFlag && st_ff.phase == 2'b00)
    else $error("run timeout wrong");
  a_sst_length: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(st_ff.phase == rsc_pkg::RSC_SST) && !crystalSource
    |-> st_ff.cnt == 32'd2) else $error("rc start-up count wrong");

endmodule

// file: tb_mcu_reset_source_control.sv
`timescale 1ns/1ps

module tb_mcu_reset_source_control;
  logic mclk, reset_n, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] pstrb;
  logic pready, pslverr, ena, pinN, sup, tick, xtal, pd, dog;
  logic pinLow, supLow, dogReq;
  logic [4:0] dogCode;
  logic coreRstN, pcSpClear, portsPreset, hold, ldOut, ldOe, portIn;
  logic [7:0] presetVal;
  logic [7:0] codes [4];
  logic [1:0] level;
  int failCount, comparisons, n;

  rsc_reset_ctrl #(.POR_CYC(20), .RST_CYC(10), .UV_MIN_CYC(4)) i_dut (
    .mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .extRstEnable(ena), .extRstPinN(pinN), .lowSupplyRaw(sup),
    .subClkTick(tick), .crystalSource(xtal), .powerDown(pd),
    .dogTimeout(dog), .dogEnableCode(dogCode), .coreRstN(coreRstN),
    .pcSpClear(pcSpClear), .portsPreset(portsPreset),
    .portPresetValue(presetVal), .pinHoldActive(hold),
    .lowDrivenPinOut(ldOut), .lowDrivenPinOe(ldOe),
    .sharedPortPinIn(portIn), .thresholdLevel(level));

  rsc_far_side i_far (
    .mclk(mclk), .reset_n(reset_n), .pinLowReq(pinLow),
    .supplyLowReq(supLow), .dogReq(dogReq), .extRstPinN(pinN),
    .lowSupplyRaw(sup), .subClkTick(tick), .dogTimeout(dog));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // -----------------------------------------------------------------
  // Checking and bus tasks
  // -----------------------------------------------------------------
  task automatic summarize();
    $display("Checks: %0d failures: %0d", comparisons, failCount);
    if (failCount == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", what, e, g);
      failCount++;
    end
  endtask

  // Zero-wait slave, but the master still waits on pready
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && k < 50)
    begin
      @(posedge mclk);
      k++;
    end
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50)
    begin
      failCount++;
      summarize();
    end
    @(posedge mclk);
  endtask

  // Cycles until coreRstN reaches the wanted level
  task automatic waitCore(input logic want);
    n = 0;
    while (coreRstN !== want && n < 3000)
    begin
      @(posedge mclk);
      n++;
    end
    if (n >= 3000)
    begin
      failCount++;
      summarize();
    end
  endtask

  // -----------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'h1;
    {ena, pinLow, supLow, dogReq, pd, xtal} = '0;
    dogCode = rsc_pkg::DOG_ENABLE;
    failCount = 0;
    comparisons = 0;
    reset_n = 1'b0;
    repeat (10) @(posedge mclk);
    chk("port preset", 32'h1FF, {portsPreset, presetVal});
    reset_n <= 1'b1;
    waitCore(1'b1);
    chk("power-on delay", 1, n >= 20);
    chk("port preset off", 0, portsPreset);
    apb(1'b0, rsc_pkg::ADDR_THRESH, 0);
    chk("threshold reset", 32'h55, q[7:0]);
    codes[0] = rsc_pkg::CODE_2V10;
    codes[1] = rsc_pkg::CODE_2V55;
    codes[2] = rsc_pkg::CODE_3V15;
    codes[3] = rsc_pkg::CODE_3V80;
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, rsc_pkg::ADDR_THRESH, {24'h0, codes[i]});
      chk("threshold level", i, level);
    end
    apb(1'b1, rsc_pkg::ADDR_CAUSE, 32'hFF);
    apb(1'b0, rsc_pkg::ADDR_CAUSE, 0);
    chk("cause unused", 0, q[6:3]);
    apb(1'b1, rsc_pkg::ADDR_THRESH, 32'h12);
    waitCore(1'b0);
    waitCore(1'b1);
    apb(1'b0, rsc_pkg::ADDR_THRESH, 0);
    chk("threshold restored", 32'h55, q[7:0]);
    apb(1'b0, rsc_pkg::ADDR_CAUSE, 0);
    chk("bad code flag", 1, q[1]);
    apb(1'b1, rsc_pkg::ADDR_CAUSE, 0);
    apb(1'b0, rsc_pkg::ADDR_CAUSE, 0);
    chk("flags cleared", 0, q[2:0]);
    apb(1'b1, rsc_pkg::ADDR_THRESH, 32'hAA);
    supLow <= 1'b1;
    repeat (2) @(posedge mclk);
    supLow <= 1'b0;
    repeat (60) @(posedge mclk);
    chk("short dip", 1, coreRstN);
    pd <= 1'b1;
    supLow <= 1'b1;
    repeat (60) @(posedge mclk);
    chk("dip in power-down", 1, coreRstN);
    pd <= 1'b0;
    waitCore(1'b0);
    chk("undervoltage latency", 1, n <= 40);
    chk("no pin drive", 0, ldOe);
    supLow <= 1'b0;
    waitCore(1'b1);
    apb(1'b0, rsc_pkg::ADDR_THRESH, 0);
    chk("threshold kept", 32'hAA, q[7:0]);
    apb(1'b0, rsc_pkg::ADDR_CAUSE, 0);
    chk("undervoltage flag", 1, q[2]);
    ena <= 1'b1;
    pinLow <= 1'b1;
    repeat (5) @(posedge mclk);
    chk("pin reset", 0, coreRstN);
    chk("pin hold", 3'b110, {hold, ldOe, ldOut});
    pinLow <= 1'b0;
    waitCore(1'b1);
    chk("reset delay", 1, n >= 10 && n < 60);
    apb(1'b0, rsc_pkg::ADDR_STATUS, 0);
    chk("flags after pin", 0, q[1:0]);
    ena <= 1'b0;
    pinLow <= 1'b1;
    repeat (5) @(posedge mclk);
    chk("port pin", 2'b10, {coreRstN, portIn});
    pinLow <= 1'b0;
    dogReq <= 1'b1;
    waitCore(1'b0);
    dogReq <= 1'b0;
    waitCore(1'b1);
    apb(1'b0, rsc_pkg::ADDR_STATUS, 0);
    chk("run timeout", 2'b01, q[1:0]);
    pd <= 1'b1;
    dogReq <= 1'b1;
    n = 0;
    while (pcSpClear !== 1'b1 && n < 20)
    begin
      @(posedge mclk);
      n++;
    end
    chk("sleep timeout", 2'b11, {pcSpClear, coreRstN});
    dogReq <= 1'b0;
    pd <= 1'b0;
    apb(1'b0, rsc_pkg::ADDR_STATUS, 0);
    chk("sleep flags", 2'b11, q[1:0]);
    dogCode <= 5'h1F;
    waitCore(1'b0);
    dogCode <= rsc_pkg::DOG_ENABLE;
    waitCore(1'b1);
    apb(1'b0, rsc_pkg::ADDR_CAUSE, 0);
    chk("bad dog flag", 1, q[0]);
    xtal <= 1'b1;
    ena <= 1'b1;
    pinLow <= 1'b1;
    repeat (5) @(posedge mclk);
    pinLow <= 1'b0;
    waitCore(1'b1);
    chk("crystal start-up", 1, n >= 1034);
    summarize();
  end
endmodule
